// ===== rtl/zcp_mains_zero_cross.sv
`timescale 1ns/100ps
`include "zcp_defs.svh"

module zcp_mains_zero_cross #(
  parameter int TICK_CYC = `ZCP_TICK_CYC,
  parameter int MS_CYC = `ZCP_MS_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mains_sense_input_i,
  input wire logic tx_active_i,
  input wire logic current_hit_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic zero_cross_o
);

  // ===========================================================
  // Declarations
  zcp_pkg::zcp_edge_sel_t edge_sel;
  zcp_pkg::zcp_pwr_t pwr;
  zcp_pkg::zcp_vstate_t vstate;
  zcp_pkg::zcp_vstate_t next_vstate;
  logic continuous_measure_force;
  logic [15:0] measure_window_ms;
  logic [19:0] time_now;
  logic [19:0] timestamp;
  logic [19:0] prev_edge;
  logic [19:0] mid_time;
  logic [19:0] half_period;
  logic [19:0] vcount;
  logic sense_q;
  logic rise_ev;
  logic fall_ev;
  logic any_ev;
  logic virt_ev;
  logic real_ev;
  logic tick_10us;
  logic tick_ms;
  logic pwr_done;
  logic [18:0] pwr_value;
  logic [31:0] ts_word;
  logic [23:0] pwr_word;

  // Forward distance between two times, wrapping at one million
  function automatic logic [19:0] wrap_diff(input logic [19:0] a, input logic [19:0] b);
    logic [20:0] d;
    d = {1'b0, a} - {1'b0, b};
    if (a < b) begin
      d = d + {1'b0, `ZCP_TS_MAX} + 21'h0_0001;
    end
    wrap_diff = d[19:0];
  endfunction : wrap_diff

  // Advance a time by a step, wrapping at one million
  function automatic logic [19:0] wrap_add(input logic [19:0] a, input logic [19:0] b);
    logic [20:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s > {1'b0, `ZCP_TS_MAX}) begin
      s = s - {1'b0, `ZCP_TS_MAX} - 21'h0_0001;
    end
    wrap_add = s[19:0];
  endfunction : wrap_add

  // ===========================================================
  // Tick sources
  zcp_tick_gen #(.DIV(TICK_CYC)) u_tick_10us (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick_10us)
  );

  zcp_tick_gen #(.DIV(MS_CYC)) u_tick_ms (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick_ms)
  );

  // ===========================================================
  // Free-running time base in 10 us steps, wraps after one million
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      time_now <= 20'h0_0000;
    end else if (tick_10us) begin
      time_now <= wrap_add(time_now, 20'h0_0001);
    end
  end

  // ===========================================================
  // Edge detection on the mains sense input
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sense_q <= 1'b0;
    end else begin
      sense_q <= mains_sense_input_i;
    end
  end

  assign rise_ev = mains_sense_input_i && !sense_q && edge_sel.rise;
  assign fall_ev = !mains_sense_input_i && sense_q && edge_sel.fall;
  assign real_ev = rise_ev || fall_ev;
  assign any_ev = mains_sense_input_i ^ sense_q;

  // ===========================================================
  // Virtual edge: after two edges, the midpoint is reported half the last
  // edge-to-edge span after each edge, since the real crossing is not seen until then
  assign mid_time = wrap_add(prev_edge, {1'b0, half_period[19:1]});

  always_comb begin
    next_vstate = vstate;
    case (vstate)
      zcp_pkg::ZCP_V_IDLE: begin
        if (edge_sel.virt && any_ev) begin
          next_vstate = zcp_pkg::ZCP_V_HALF;
        end
      end
      zcp_pkg::ZCP_V_HALF: begin
        if (!edge_sel.virt) begin
          next_vstate = zcp_pkg::ZCP_V_IDLE;
        end else if (any_ev) begin
          next_vstate = zcp_pkg::ZCP_V_ARMED;
        end
      end
      zcp_pkg::ZCP_V_ARMED: begin
        if (!edge_sel.virt) begin
          next_vstate = zcp_pkg::ZCP_V_IDLE;
        end
      end
      default: begin
        next_vstate = zcp_pkg::ZCP_V_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vstate <= zcp_pkg::ZCP_V_IDLE;
    end else begin
      vstate <= next_vstate;
    end
  end

  // Remember the last edge and the span to it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_edge <= 20'h0_0000;
      half_period <= 20'h0_0000;
    end else if (any_ev) begin
      prev_edge <= time_now;
      half_period <= wrap_diff(time_now, prev_edge);
    end
  end

  // Count down to the midpoint of the current interval
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vcount <= 20'h0_0000;
    end else if (any_ev) begin
      vcount <= wrap_diff(time_now, prev_edge) >> 1;
    end else if (tick_10us && vcount != 20'h0_0000) begin
      vcount <= vcount - 20'h0_0001;
    end
  end

  assign virt_ev = (vstate == zcp_pkg::ZCP_V_ARMED) && edge_sel.virt && tick_10us &&
                   (vcount == 20'h0_0001) && !any_ev;

  // ===========================================================
  // Timestamp capture, hardware only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timestamp <= 20'h0_0000;
      zero_cross_o <= 1'b0;
    end else begin
      zero_cross_o <= real_ev || virt_ev;
      if (virt_ev) begin
        timestamp <= wrap_add(time_now, 20'h0_0001);
      end else if (real_ev) begin
        timestamp <= time_now;
      end
    end
  end

  assign ts_word = {timestamp, 12'h000};

  // ===========================================================
  // Power measurement
  zcp_power_meter u_power (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ms_tick_i(tick_ms),
    .window_ms_i(measure_window_ms),
    .sample_en_i(tx_active_i || continuous_measure_force),
    .current_hit_i(current_hit_i),
    .done_o(pwr_done),
    .result_o(pwr_value)
  );

  // Result and flag; a fresh value beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr <= '0;
    end else if (pwr_done) begin
      pwr.value <= pwr_value;
      pwr.new_flag <= 1'b1;
    end else if (wr_i && addr_i == `ZCP_ADDR_PWR0 && !wdata_i[`ZCP_BIT_PWR_FLAG]) begin
      pwr.new_flag <= 1'b0;
    end
  end

  assign pwr_word = {4'h0, pwr.new_flag, pwr.value};

  // ===========================================================
  // Software writable configuration
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      edge_sel <= zcp_pkg::zcp_edge_sel_t'(`ZCP_RST_EDGE_SEL);
    end else if (wr_i && addr_i == `ZCP_ADDR_EDGE_SEL) begin
      edge_sel <= wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      continuous_measure_force <= 1'b0;
    end else if (wr_i && addr_i == `ZCP_ADDR_CTRL) begin
      continuous_measure_force <= wdata_i[`ZCP_BIT_CONT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      measure_window_ms <= `ZCP_RST_WIN_MS;
    end else if (wr_i && addr_i == `ZCP_ADDR_WIN_LO) begin
      measure_window_ms[7:0] <= wdata_i;
    end else if (wr_i && addr_i == `ZCP_ADDR_WIN_HI) begin
      measure_window_ms[15:8] <= wdata_i;
    end
  end

  // ===========================================================
  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ZCP_ADDR_TS0: rdata_o <= ts_word[31:24];
        `ZCP_ADDR_TS1: rdata_o <= ts_word[23:16];
        `ZCP_ADDR_TS2: rdata_o <= ts_word[15:8];
        `ZCP_ADDR_TS3: rdata_o <= ts_word[7:0];
        `ZCP_ADDR_EDGE_SEL: rdata_o <= {5'h00, edge_sel};
        `ZCP_ADDR_PWR0: rdata_o <= pwr_word[23:16];
        `ZCP_ADDR_PWR1: rdata_o <= pwr_word[15:8];
        `ZCP_ADDR_PWR2: rdata_o <= pwr_word[7:0];
        `ZCP_ADDR_CTRL: rdata_o <= {7'h00, continuous_measure_force};
        `ZCP_ADDR_WIN_LO: rdata_o <= measure_window_ms[7:0];
        `ZCP_ADDR_WIN_HI: rdata_o <= measure_window_ms[15:8];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : zcp_mains_zero_cross

// ===== rtl/zcp_defs.svh
`ifndef ZCP_DEFS_SVH
`define ZCP_DEFS_SVH

// Register offsets (16-bit byte addresses on the 8-bit register data port)
`define ZCP_ADDR_TS0 16'hfe69
`define ZCP_ADDR_TS1 16'hfe6a
`define ZCP_ADDR_TS2 16'hfe6b
`define ZCP_ADDR_TS3 16'hfe6c
`define ZCP_ADDR_EDGE_SEL 16'hfe6d
`define ZCP_ADDR_PWR0 16'hfe7d
`define ZCP_ADDR_PWR1 16'hfe7e
`define ZCP_ADDR_PWR2 16'hfe7f
`define ZCP_ADDR_CTRL 16'hfe70
`define ZCP_ADDR_WIN_LO 16'hfe71
`define ZCP_ADDR_WIN_HI 16'hfe72

// Field positions
`define ZCP_BIT_FALL 0
`define ZCP_BIT_RISE 1
`define ZCP_BIT_VIRT 2
`define ZCP_BIT_PWR_FLAG 3
`define ZCP_BIT_CONT 0

// Reset values
`define ZCP_RST_EDGE_SEL 8'h06
`define ZCP_RST_WIN_MS 16'h0064

// Timing: 10 us tick and 1 ms tick at 200 MHz
`define ZCP_CLK_MHZ 200
`define ZCP_TICK_US 10
`define ZCP_TICK_CYC (`ZCP_TICK_US * `ZCP_CLK_MHZ)
`define ZCP_MS_CYC (1000 * `ZCP_CLK_MHZ)
`define ZCP_TS_MAX 20'hf_4240

`endif

// ===== rtl/zcp_pkg.sv
package zcp_pkg;

  // Edge selection carried as one group
  typedef struct packed {
    logic virt;
    logic rise;
    logic fall;
  } zcp_edge_sel_t;

  // Power measurement result as seen by software
  typedef struct packed {
    logic new_flag;
    logic [18:0] value;
  } zcp_pwr_t;

  // Virtual edge tracker states
  typedef enum logic [2:0] {
    ZCP_V_IDLE = 3'b001,
    ZCP_V_HALF = 3'b010,
    ZCP_V_ARMED = 3'b100
  } zcp_vstate_t;

endpackage : zcp_pkg

// ===== rtl/zcp_tick_gen.sv
`timescale 1ns/100ps
`include "zcp_defs.svh"

// Free-running divider giving a one-cycle tick every DIV clocks
module zcp_tick_gen #(
  parameter int DIV = `ZCP_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic tick_o
);

  logic [31:0] count;

  // ===========================================================
  // Divider
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || count == 32'(DIV - 1)) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

  assign tick_o = (count == 32'(DIV - 1));

endmodule : zcp_tick_gen

// ===== rtl/zcp_power_meter.sv
`timescale 1ns/100ps
`include "zcp_defs.svh"

// Counts sampled consumption cycles over one window of milliseconds
module zcp_power_meter (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ms_tick_i,
  input wire logic [15:0] window_ms_i,
  input wire logic sample_en_i,
  input wire logic current_hit_i,
  output logic done_o,
  output logic [18:0] result_o
);

  logic [15:0] ms_count;
  logic [18:0] acc;
  logic window_end;
  logic [18:0] acc_next;

  // Count including this cycle, so the sample at a window end is not lost
  assign acc_next = (sample_en_i && current_hit_i && acc != 19'h7_ffff) ?
                    acc + 19'h0_0001 : acc;

  // Window ends when the configured ms count is reached (zero treated as one)
  assign window_end = ms_tick_i && (ms_count + 16'h0001 >= window_ms_i);

  // ===========================================================
  // Window timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || window_end) begin
      ms_count <= 16'h0000;
    end else if (ms_tick_i) begin
      ms_count <= ms_count + 16'h0001;
    end
  end

  // Saturating accumulator, cleared at each window end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || window_end) begin
      acc <= 19'h0_0000;
    end else if (sample_en_i && current_hit_i && acc != 19'h7_ffff) begin
      acc <= acc + 19'h0_0001;
    end
  end

  // Result and strobe registered
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_o <= 19'h0_0000;
      done_o <= 1'b0;
    end else begin
      done_o <= window_end;
      if (window_end) begin
        result_o <= acc_next;
      end
    end
  end

endmodule : zcp_power_meter

// ===== tb/zcp_mains_model.sv
`timescale 1ns/100ps
// ==========
// Mains sense source
module zcp_mains_model #(
  parameter int HIGH_CYC = 40,
  parameter int LOW_CYC = 24
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic mains_o
);
  int cnt;
  // Level starts low so reset sees no edge
  initial mains_o = 1'b0;
  // Unequal halves, so midpoint and edge timing differ
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
    end else if (cnt == (mains_o ? HIGH_CYC : LOW_CYC) - 1) begin
      cnt <= 0;
      mains_o <= ~mains_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : zcp_mains_model

// ===== tb/zcp_mains_zero_cross_chk.sv
`timescale 1ns/100ps
`include "zcp_defs.svh"
// ==========
// Port checker
module zcp_mains_zero_cross_chk #(
  parameter int TICK_CYC = 4,
  parameter int MS_CYC = 40
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mains_sense_input_i,
  input wire logic tx_active_i,
  input wire logic current_hit_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic zero_cross_o
);
  logic [2:0] edge_sel;
  logic prev_mains;
  logic edge_hit;
  logic mapped;
  // Shadow of the selection, so the checker needs no internal probes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      edge_sel <= 3'h6;
    end else if (wr_i && addr_i == `ZCP_ADDR_EDGE_SEL) begin
      edge_sel <= wdata_i[2:0];
    end
  end
  // Previous input sample
  always_ff @(posedge clk_i) begin
    prev_mains <= mains_sense_input_i;
  end
  // Selected edges and decoded addresses
  assign edge_hit = (mains_sense_input_i && !prev_mains && edge_sel[1]) ||
    (!mains_sense_input_i && prev_mains && edge_sel[0]);
  assign mapped = addr_i inside {[16'hfe69:16'hfe6d], [16'hfe70:16'hfe72],
    [16'hfe7d:16'hfe7f]};
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_SEL_READ: assert property (rd_i && addr_i == `ZCP_ADDR_EDGE_SEL
    |=> rdata_o == {5'h00, edge_sel}) else $error("edge select readback wrong");
  AST_TS_B3: assert property (rd_i && addr_i == `ZCP_ADDR_TS3 |=> rdata_o == 8'h00)
    else $error("timestamp low byte not zero");
  AST_TS_B2: assert property (rd_i && addr_i == `ZCP_ADDR_TS2
    |=> rdata_o[3:0] == 4'h0) else $error("timestamp low nibble not zero");
  AST_PWR_TOP: assert property (rd_i && addr_i == `ZCP_ADDR_PWR0
    |=> rdata_o[7:4] == 4'h0) else $error("power top bits not zero");
  AST_RISE: assert property (edge_hit && mains_sense_input_i |=> zero_cross_o)
    else $error("rising edge gave no pulse");
  AST_FALL: assert property (edge_hit && !mains_sense_input_i |=> zero_cross_o)
    else $error("falling edge gave no pulse");
  AST_NO_SPUR: assert property (zero_cross_o && !edge_sel[2] && !$past(edge_sel[2])
    |-> $past(edge_hit)) else $error("pulse without selected edge");
  // Main scenarios
  COV_VIRT: cover property (zero_cross_o && edge_sel[2]);
  COV_EDGE: cover property (edge_hit);
  COV_PWR: cover property (rd_i && addr_i == `ZCP_ADDR_PWR0);
endmodule : zcp_mains_zero_cross_chk

bind zcp_mains_zero_cross zcp_mains_zero_cross_chk #(.TICK_CYC(TICK_CYC), .MS_CYC(MS_CYC))
  u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mains_sense_input_i(mains_sense_input_i),
  .tx_active_i(tx_active_i), .current_hit_i(current_hit_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .zero_cross_o(zero_cross_o));

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "zcp_defs.svh"
// ==========
// Bench top
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tx_active_i = 1'b0;
  logic current_hit_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic run = 1'b0;
  logic mains;
  logic [7:0] rdata_o;
  logic zero_cross_o;
  logic [7:0] d;
  logic [19:0] ta;
  logic [19:0] tz;
  logic [18:0] pv;
  int mismatches = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // Short ticks: 10 us is 4 cycles, 1 ms is 40 cycles
  zcp_mains_zero_cross #(.TICK_CYC(4), .MS_CYC(40)) u_dut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .mains_sense_input_i(mains), .tx_active_i(tx_active_i),
    .current_hit_i(current_hit_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .zero_cross_o(zero_cross_o));
  zcp_mains_model #(.HIGH_CYC(40), .LOW_CYC(24)) u_mains (.clk_i(clk_i), .run_i(run),
    .mains_o(mains));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Bytes are not latched together, so read well clear of the next event
  task automatic read_ts(output logic [19:0] t);
    rd(`ZCP_ADDR_TS0);
    t[19:12] = d;
    rd(`ZCP_ADDR_TS1);
    t[11:4] = d;
    rd(`ZCP_ADDR_TS2);
    t[3:0] = d[7:4];
    chk(d[3:0], 4'h0, "timestamp low nibble");
  endtask : read_ts
  task automatic wait_zc();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (zero_cross_o !== 1'b1 && n < 300);
    chk(zero_cross_o, 1'b1, "crossing pulse");
  endtask : wait_zc
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      rd(`ZCP_ADDR_PWR0);
      n++;
    end while (d[3] !== 1'b1 && n < 200);
  endtask : wait_flag
  // First result after a change may cover a partial window; judge the next one
  task automatic measure(input logic [18:0] exp);
    wr(`ZCP_ADDR_PWR0, 8'h00);
    wait_flag();
    wr(`ZCP_ADDR_PWR0, 8'h00);
    wait_flag();
    chk(d[3], 1'b1, "new flag");
    pv[18:16] = d[2:0];
    rd(`ZCP_ADDR_PWR1);
    pv[15:8] = d;
    rd(`ZCP_ADDR_PWR2);
    pv[7:0] = d;
    chk(pv, exp, "power value");
  endtask : measure
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // ==========
  // Tests
  initial begin : main
    logic [7:0] cfg [6] = '{8'h02, 8'h01, 8'h03, 8'h06, 8'h04, 8'h05};
    logic [19:0] gap [6] = '{20'h0_0010, 20'h0_0010, 20'h0_000a, 20'h0_0003,
      20'h0_000c, 20'h0_0007};
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`ZCP_ADDR_EDGE_SEL);
    chk(d, 8'h06, "edge select reset");
    wr(`ZCP_ADDR_TS0, 8'hff);
    wr(`ZCP_ADDR_EDGE_SEL, 8'hff);
    rd(`ZCP_ADDR_EDGE_SEL);
    chk(d, 8'h07, "edge select bits");
    read_ts(ta);
    chk(ta, 20'h0_0000, "timestamp reset, write ignored");
    for (int i = 0; i < 3; i++) begin
      rd(16'(`ZCP_ADDR_PWR0 + i));
      chk(d, 8'h00, "power reset");
    end
    rd(16'hfe60);
    chk(d, 8'h00, "unmapped read");
    $display("test reset done");
    // Spacing of successive events per selection, in 10 us steps
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(`ZCP_ADDR_EDGE_SEL, cfg[i]);
      repeat (200) @(posedge clk_i);
      @(posedge mains);
      wait_zc();
      read_ts(ta);
      wait_zc();
      read_ts(tz);
      chk(tz - ta, gap[i], "event spacing");
    end
    $display("test edges done");
    // One 2 ms window is 80 cycles, all sampled high
    wr(`ZCP_ADDR_WIN_LO, 8'h02);
    wr(`ZCP_ADDR_WIN_HI, 8'h00);
    tx_active_i <= 1'b1;
    measure(19'h0_0050);
    rd(`ZCP_ADDR_PWR0);
    chk(d[3], 1'b1, "flag holds");
    wr(`ZCP_ADDR_PWR0, 8'h00);
    rd(`ZCP_ADDR_PWR0);
    chk(d[3], 1'b0, "flag cleared");
    tx_active_i <= 1'b0;
    measure(19'h0_0000);
    wr(`ZCP_ADDR_CTRL, 8'h01);
    measure(19'h0_0050);
    $display("test power done");
    give_verdict();
  end
  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin : watchdog
    repeat (30000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule : tb
